// ===== logic/sdps_map.svh
// offsets, field positions, channel count and strapped index bases for strap decode and pin select
`ifndef SDPS_MAP_SVH
`define SDPS_MAP_SVH

`define SDPS_TAPE_REG_ADDR     10'h3F3
`define SDPS_FUNC_TAPE_BIT     1
`define SDPS_ADV_XRATE0_BIT    0
`define SDPS_ADV_DTYPE_LO_BIT  1
`define SDPS_ADV_DTYPE_HI_BIT  2
`define SDPS_ADV_XRATE1_BIT    4
`define SDPS_STRAP_FAST_BIT    0
`define SDPS_NUM_CHAN          2
`define SDPS_INDEX_BASE0       16'h0398
`define SDPS_INDEX_BASE1       16'h026E
`define SDPS_INDEX_BASE2       16'h015C
`define SDPS_INDEX_BASE3       16'h002E

`endif

// ===== logic/sdps_pkg.sv
// types shared by strap decode and pin select
`default_nettype none
package sdps_pkg;
   typedef logic [1:0] sdps_rate_t;
   typedef logic [4:0] sdps_cfg_t;
   typedef logic [1:0] sdps_base_t;
   typedef enum logic [2:0]
   {
      SDPS_ST_RESET = 3'b001,
      SDPS_ST_CAPT  = 3'b010,
      SDPS_ST_RUN   = 3'b100
   } sdps_state_e;
endpackage
`default_nettype wire

// ===== logic/sdps_strap_if.sv
// strap values passed from the strap latch to the top
`timescale 1ns/1ns
`default_nettype none
interface sdps_strap_if;
   import sdps_pkg::*;
   logic       fast_clk;
   sdps_cfg_t  cfg;
   sdps_base_t base;
   logic       valid;
   modport latch (output fast_clk, output cfg, output base, output valid);
   modport user  (input fast_clk, input cfg, input base, input valid);
endinterface
`default_nettype wire

// ===== logic/sdps_strap_latch.sv
// captures the power-up straps at reset release
`timescale 1ns/1ns
`default_nettype none
`include "sdps_map.svh"
module sdps_strap_latch
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // strap pins
   input  wire logic        fast_clock_strap,
   input  wire logic [4:0]  power_up_config_straps,
   input  wire logic [1:0]  base_select_straps,
   // captured values
   sdps_strap_if.latch      sif
);
   import sdps_pkg::*;

   sdps_state_e st_q;
   sdps_state_e st_d;
   logic        fast_q;
   logic        fast_d;
   sdps_cfg_t   cfg_q;
   sdps_cfg_t   cfg_d;
   sdps_base_t  base_q;
   sdps_base_t  base_d;

   // async reset only loads constants; pins sampled on second clock after release
   always_comb
   begin
      st_d   = st_q;
      fast_d = fast_q;
      cfg_d  = cfg_q;
      base_d = base_q;
      case (st_q)
         SDPS_ST_RESET:
         begin
            st_d = SDPS_ST_CAPT;
         end
         SDPS_ST_CAPT:
         begin
            fast_d = fast_clock_strap;
            cfg_d  = power_up_config_straps;
            base_d = base_select_straps;
            st_d   = SDPS_ST_RUN;
         end
         SDPS_ST_RUN:
         begin
            st_d = SDPS_ST_RUN;
         end
         default:
         begin
            st_d = SDPS_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q   <= SDPS_ST_RESET;
         fast_q <= 1'b0;
         cfg_q  <= 5'h00;
         base_q <= 2'h0;
      end
      else
      begin
         st_q   <= st_d;
         fast_q <= fast_d;
         cfg_q  <= cfg_d;
         base_q <= base_d;
      end
   end

   assign sif.fast_clk = fast_q;
   assign sif.cfg      = cfg_q;
   assign sif.base     = base_q;
   assign sif.valid    = (st_q == SDPS_ST_RUN);
endmodule
`default_nettype wire

// ===== logic/sdps_uart_pin.sv
// per-channel serial output pin select
`timescale 1ns/1ns
`default_nettype none
module sdps_uart_pin
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // channel controls
   input  wire logic test_mode,
   input  wire logic divisor_latch_access,
   input  wire logic serial_tx_out,
   input  wire logic baud_tap,
   // pin
   output logic      pin_q
);
   logic pin_d;

   always_comb
   begin
      if (test_mode && divisor_latch_access)
         pin_d = baud_tap;
      else
         pin_d = serial_tx_out;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         pin_q <= 1'b1;
      else
         pin_q <= pin_d;
   end
endmodule
`default_nettype wire

// ===== logic/sdps_top.sv
// host address qualification, shared pin routing and strap decode
`timescale 1ns/1ns
`default_nettype none
`include "sdps_map.svh"
module sdps_top
(
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   // host bus
   input  wire logic [10:0]          host_addr,
   input  wire logic                 host_io_rd,
   input  wire logic                 host_io_wr,
   input  wire logic                 dma_ack,
   input  wire logic                 addr_decode_inhibit,
   // configuration bits
   input  wire logic [7:0]           function_control_reg,
   input  wire logic [7:0]           advanced_config_reg,
   // floppy rate writes
   input  wire logic                 config_control_wr,
   input  wire logic                 rate_select_wr,
   input  wire logic [1:0]           host_wdata,
   // default pin functions
   input  wire logic                 xrate0_pin_default,
   input  wire logic                 density_select_out,
   input  wire logic                 tape_pin_default,
   input  wire logic                 drive_type_pin_in,
   // serial channels
   input  wire logic                 test_mode,
   input  wire logic [1:0]           divisor_latch_access,
   input  wire logic [1:0]           serial_tx_out,
   input  wire logic [1:0]           baud_tap,
   // straps
   input  wire logic                 fast_clock_strap,
   input  wire logic [4:0]           power_up_config_straps,
   input  wire logic [1:0]           base_select_straps,
   // qualified selects
   output logic                      tape_reg_read_strobe,
   output logic                      index_sel,
   output logic                      data_sel,
   output logic                      dma_cycle,
   // shared pins
   output logic                      tape_pin_out,
   output logic                      tape_pin_oe,
   output logic                      drive_type_in_second,
   output logic [1:0]                primary_rate_outputs,
   output logic [1:0]                extra_rate_outputs,
   output logic                      xrate0_pin,
   output logic                      density_pin,
   output logic [1:0]                baud_tap_output,
   // strap results
   output logic [7:0]                strap_latch_reg,
   output sdps_pkg::sdps_cfg_t       default_config,
   output logic [15:0]               index_base,
   output logic                      straps_valid
);
   import sdps_pkg::*;

   sdps_strap_if sif ();

   function automatic logic [15:0] base_of(input sdps_base_t b);
      case (b)
         2'h0:    base_of = `SDPS_INDEX_BASE0;
         2'h1:    base_of = `SDPS_INDEX_BASE1;
         2'h2:    base_of = `SDPS_INDEX_BASE2;
         default: base_of = `SDPS_INDEX_BASE3;
      endcase
   endfunction

   // index/data decode ignores the top address bit, like the tape port
   function automatic logic addr_hit(input logic [10:0] a, input logic [15:0] b);
      addr_hit = (a[9:0] == b[9:0]);
   endfunction

   function automatic logic dtype_mode(input logic [7:0] func_bits, input logic [7:0] adv_bits);
      dtype_mode = !func_bits[`SDPS_FUNC_TAPE_BIT]
                   && adv_bits[`SDPS_ADV_DTYPE_HI_BIT]
                   && !adv_bits[`SDPS_ADV_DTYPE_LO_BIT];
   endfunction

   // host decode state
   // selects are levels, registered one clock after the request
   logic        strobe_q;
   logic        strobe_d;
   logic        isel_q;
   logic        isel_d;
   logic        dsel_q;
   logic        dsel_d;
   logic        dma_q;
   logic        dma_d;
   logic        io_ok;

   always_comb
   begin
      dma_d = dma_ack;
      io_ok = !addr_decode_inhibit && !dma_ack;
      // 3F3 read decode, bit 10 ignored
      strobe_d = io_ok && host_io_rd && (host_addr[9:0] == `SDPS_TAPE_REG_ADDR);
      // index/data at strapped base
      // selects wait for the straps to settle
      isel_d = io_ok && (host_io_rd || host_io_wr) && sif.valid
               && addr_hit(host_addr, base_of(sif.base));
      dsel_d = io_ok && (host_io_rd || host_io_wr) && sif.valid
               && addr_hit(host_addr, base_of(sif.base) + 16'h0001);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         strobe_q <= 1'b0;
         isel_q   <= 1'b0;
         dsel_q   <= 1'b0;
         dma_q    <= 1'b0;
      end
      else
      begin
         strobe_q <= strobe_d;
         isel_q   <= isel_d;
         dsel_q   <= dsel_d;
         dma_q    <= dma_d;
      end
   end

   // rate mirror and pin mux state
   sdps_rate_t  rate_q;
   sdps_rate_t  rate_d;
   logic        tpin_q;
   logic        tpin_d;
   logic        toe_q;
   logic        toe_d;
   logic        drid_q;
   logic        drid_d;
   logic        x0_q;
   logic        x0_d;
   logic        den_q;
   logic        den_d;

   always_comb
   begin
      rate_d = rate_q;
      // last rate write wins
      // rate select wins a same-cycle tie; both carry the same value
      if (rate_select_wr)
         rate_d = host_wdata;
      else if (config_control_wr)
         rate_d = host_wdata;
      // registered outputs: one flop per pin keeps mux changes glitch-free
      // tape strobe on shared pin
      if (function_control_reg[`SDPS_FUNC_TAPE_BIT])
      begin
         tpin_d = strobe_d;
         toe_d  = 1'b1;
      end
      else if (dtype_mode(function_control_reg, advanced_config_reg))
      begin
         // input mode releases the pin to the drive
         tpin_d = 1'b0;
         toe_d  = 1'b0;
      end
      else
      begin
         tpin_d = tape_pin_default;
         toe_d  = 1'b1;
      end
      drid_d = dtype_mode(function_control_reg, advanced_config_reg)
               ? drive_type_pin_in : 1'b0;
      x0_d  = advanced_config_reg[`SDPS_ADV_XRATE0_BIT] ? rate_d[0] : xrate0_pin_default;
      den_d = advanced_config_reg[`SDPS_ADV_XRATE1_BIT] ? rate_d[1] : density_select_out;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rate_q <= 2'h0;
         tpin_q <= 1'b0;
         toe_q  <= 1'b0;
         drid_q <= 1'b0;
         x0_q   <= 1'b0;
         den_q  <= 1'b0;
      end
      else
      begin
         rate_q <= rate_d;
         tpin_q <= tpin_d;
         toe_q  <= toe_d;
         drid_q <= drid_d;
         x0_q   <= x0_d;
         den_q  <= den_d;
      end
   end

   // strap latch
   sdps_strap_latch u_strap
   (
      .mclk                   (mclk),
      .rst_b                  (rst_b),
      .fast_clock_strap       (fast_clock_strap),
      .power_up_config_straps (power_up_config_straps),
      .base_select_straps     (base_select_straps),
      .sif                    (sif)
   );

   // strap result state
   // a second stage keeps every strap output a plain flop
   // valid and base leave together, one clock after the latch reports valid
   logic [7:0]  latch_q;
   logic [7:0]  latch_d;
   sdps_cfg_t   cfg_out_q;
   sdps_cfg_t   cfg_out_d;
   logic [15:0] idx_q;
   logic [15:0] idx_d;
   logic        vld_q;
   logic        vld_d;

   always_comb
   begin
      latch_d   = {7'h00, sif.fast_clk};
      cfg_out_d = sif.cfg;
      idx_d     = base_of(sif.base);
      vld_d     = sif.valid;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         latch_q   <= 8'h00;
         cfg_out_q <= 5'h00;
         idx_q     <= 16'h0000;
         vld_q     <= 1'b0;
      end
      else
      begin
         latch_q   <= latch_d;
         cfg_out_q <= cfg_out_d;
         idx_q     <= idx_d;
         vld_q     <= vld_d;
      end
   end

   // serial pins
   // one pin per channel, each idles at transmit high from reset
   genvar ch;
   generate
      for (ch = 0; ch < `SDPS_NUM_CHAN; ch = ch + 1)
      begin : g_ser
         sdps_uart_pin u_pin
         (
            .mclk                 (mclk),
            .rst_b                (rst_b),
            .test_mode            (test_mode),
            .divisor_latch_access (divisor_latch_access[ch]),
            .serial_tx_out        (serial_tx_out[ch]),
            .baud_tap             (baud_tap[ch]),
            .pin_q                (baud_tap_output[ch])
         );
      end
   endgenerate

   assign tape_reg_read_strobe = strobe_q;
   assign index_sel            = isel_q;
   assign data_sel             = dsel_q;
   assign dma_cycle            = dma_q;
   assign tape_pin_out         = tpin_q;
   assign tape_pin_oe          = toe_q;
   assign drive_type_in_second = drid_q;
   assign primary_rate_outputs = rate_q;
   assign extra_rate_outputs   = rate_q;
   assign xrate0_pin           = x0_q;
   assign density_pin          = den_q;
   assign strap_latch_reg      = latch_q;
   assign default_config       = cfg_out_q;
   assign index_base           = idx_q;
   assign straps_valid         = vld_q;
endmodule
`default_nettype wire

// ===== tb/sdps_properties.sv
// concurrent checks on the pin select top ports
`timescale 1ns/1ns
`default_nettype none
`include "sdps_map.svh"
module sdps_properties
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_b,
   // inputs watched
   input wire logic [10:0] host_addr,
   input wire logic        host_io_rd,
   input wire logic        dma_ack,
   input wire logic        addr_decode_inhibit,
   input wire logic [7:0]  function_control_reg,
   input wire logic [7:0]  advanced_config_reg,
   input wire logic        config_control_wr,
   input wire logic        rate_select_wr,
   input wire logic [1:0]  host_wdata,
   input wire logic        drive_type_pin_in,
   input wire logic        test_mode,
   input wire logic [1:0]  divisor_latch_access,
   input wire logic [1:0]  baud_tap,
   // outputs watched
   input wire logic        tape_reg_read_strobe,
   input wire logic        index_sel,
   input wire logic        data_sel,
   input wire logic        dma_cycle,
   input wire logic        tape_pin_out,
   input wire logic        tape_pin_oe,
   input wire logic        drive_type_in_second,
   input wire logic [1:0]  extra_rate_outputs,
   input wire logic        xrate0_pin,
   input wire logic        density_pin,
   input wire logic [1:0]  baud_tap_output
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   sequence s_tape_read;
      host_io_rd && host_addr[9:0] == `SDPS_TAPE_REG_ADDR && !addr_decode_inhibit && !dma_ack;
   endsequence
   sequence s_rate_write;
      config_control_wr || rate_select_wr;
   endsequence
   AST_TAPE_STROBE: assert property (s_tape_read |=> tape_reg_read_strobe)
      else $error("tape read strobe missing");
   AST_TAPE_PIN: assert property (function_control_reg[1] |=>
      tape_pin_oe && tape_pin_out == tape_reg_read_strobe) else $error("tape pin wrong");
   AST_RATE: assert property (s_rate_write |=> extra_rate_outputs == $past(host_wdata))
      else $error("rate not taken");
   AST_XRATE0: assert property (advanced_config_reg[0] |=>
      xrate0_pin == extra_rate_outputs[0]) else $error("rate pin 0 wrong");
   AST_XRATE1: assert property (advanced_config_reg[4] |=>
      density_pin == extra_rate_outputs[1]) else $error("rate pin 1 wrong");
   AST_INHIBIT: assert property (addr_decode_inhibit && !dma_ack |=>
      !(tape_reg_read_strobe || index_sel || data_sel)) else $error("select while inhibited");
   AST_DMA: assert property (dma_ack |=> dma_cycle && !tape_reg_read_strobe && !index_sel)
      else $error("dma cycle wrong");
   AST_BAUD: assert property (test_mode && divisor_latch_access[0] |=>
      baud_tap_output[0] == $past(baud_tap[0])) else $error("baud tap not routed");
   AST_DRIVE: assert property (advanced_config_reg[2] && !advanced_config_reg[1]
      && !function_control_reg[1] |=> !tape_pin_oe && drive_type_in_second == $past(drive_type_pin_in))
      else $error("drive type input wrong");
endmodule
bind sdps_top sdps_properties u_props (.*);
`default_nettype wire

// ===== tb/sdps_strap_model.sv
// board strap resistors over weak pull-downs
`timescale 1ns/1ns
`default_nettype none
module sdps_strap_model
(
   // board setting
   input wire logic       fit_en,
   input wire logic [7:0] fit_val,
   // strap pins
   output logic           fast_clock_strap,
   output logic [4:0]     power_up_config_straps,
   output logic [1:0]     base_select_straps
);
   // unfitted resistors leave the pull-downs in charge
   always_comb
   begin
      {fast_clock_strap, power_up_config_straps, base_select_straps} = fit_en ? fit_val : 8'h00;
   end
endmodule
`default_nettype wire

// ===== tb/strap_decode_and_pin_select_test.sv
// self-checking bench for the pin select top
`timescale 1ns/1ns
`default_nettype none
`include "sdps_map.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
   $display("unexpected %s exp %0h seen %0h", nm, e, s); end end
module strap_decode_and_pin_select_test;
   import sdps_pkg::*;
   typedef struct packed {logic [10:0] a; logic rd; logic inh; logic dma; logic exp;} sdps_row_s;
   logic        mclk, rst_b, host_io_rd, host_io_wr, dma_ack, addr_decode_inhibit, fit_en;
   logic        config_control_wr, rate_select_wr, xrate0_pin_default, density_select_out;
   logic        tape_pin_default, drive_type_pin_in, test_mode, fast_clock_strap, straps_valid;
   logic        tape_reg_read_strobe, index_sel, data_sel, dma_cycle, tape_pin_out, tape_pin_oe;
   logic        drive_type_in_second, xrate0_pin, density_pin;
   logic [10:0] host_addr;
   logic [7:0]  function_control_reg, advanced_config_reg, strap_latch_reg, fit_val;
   logic [1:0]  host_wdata, divisor_latch_access, serial_tx_out, baud_tap, base_select_straps;
   logic [1:0]  primary_rate_outputs, extra_rate_outputs, baud_tap_output;
   logic [4:0]  power_up_config_straps;
   sdps_cfg_t   default_config;
   logic [15:0] index_base;
   logic [15:0] bases [4];
   sdps_row_s   rows [6];
   int          err_count, comparisons, n;

   sdps_top u_dut (.*);
   sdps_strap_model u_straps (.fit_en(fit_en), .fit_val(fit_val),
      .fast_clock_strap(fast_clock_strap), .power_up_config_straps(power_up_config_straps),
      .base_select_straps(base_select_straps));

   initial mclk = 1'h0;
   always #5 mclk = ~mclk;

   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic give_verdict;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // straps sit stable through reset, as the board holds them
   task automatic do_reset(input logic [7:0] v);
      fit_val = v;
      rst_b = 1'h0;
      step(5);
      `CHK("baud idle", 2'h3, baud_tap_output)
      rst_b = 1'h1;
      for (n = 0; n < 20 && straps_valid !== 1'h1; n++)
         step(1);
      if (n == 20)
      begin
         err_count++;
         give_verdict();
      end
   endtask

   initial
   begin
      {rst_b, host_io_rd, host_io_wr, dma_ack, addr_decode_inhibit, config_control_wr} = '0;
      {rate_select_wr, xrate0_pin_default, density_select_out, tape_pin_default} = '0;
      {drive_type_pin_in, test_mode, host_addr, host_wdata, divisor_latch_access} = '0;
      {function_control_reg, advanced_config_reg, serial_tx_out, baud_tap} = '0;
      {err_count, comparisons} = '0;
      fit_en = 1'h1;
      fit_val = 8'h00;
      bases = '{`SDPS_INDEX_BASE0, `SDPS_INDEX_BASE1, `SDPS_INDEX_BASE2, `SDPS_INDEX_BASE3};
      rows = '{{11'h3F3, 4'h9}, {11'h7F3, 4'h9}, {11'h3F3, 4'h0}, {11'h3F2, 4'h8},
               {11'h3F3, 4'hC}, {11'h3F3, 4'hA}};
      for (int b = 0; b < 4; b++)
      begin
         do_reset({b[0], 3'h5, b[1:0], b[1:0]});
         `CHK("clk strap", b[0], strap_latch_reg[0])
         `CHK("cfg", {3'h5, b[1:0]}, default_config)
         `CHK("base", bases[b], index_base)
         fit_val = ~fit_val;
         step(3);
         `CHK("strap held", b[0], strap_latch_reg[0])
      end
      $display("test straps done");
      function_control_reg = 8'h02;
      foreach (rows[i])
      begin
         {host_addr, host_io_rd, addr_decode_inhibit, dma_ack} = rows[i][14:1];
         step(1);
         `CHK("strobe", rows[i].exp, tape_reg_read_strobe)
         `CHK("tape pin", rows[i].exp, tape_pin_out)
         `CHK("tape oe", 1'h1, tape_pin_oe)
         `CHK("dma", rows[i].dma, dma_cycle)
      end
      {host_io_rd, dma_ack, addr_decode_inhibit} = '0;
      // last strap setting was base choice 3
      host_addr = bases[3][10:0];
      host_io_wr = 1'h1;
      step(1);
      `CHK("index sel", 1'h1, index_sel)
      `CHK("data idle", 1'h0, data_sel)
      host_addr = host_addr + 11'h001;
      step(1);
      `CHK("data sel", 1'h1, data_sel)
      addr_decode_inhibit = 1'h1;
      step(1);
      `CHK("data inhibit", 1'h0, data_sel)
      {host_io_wr, addr_decode_inhibit} = '0;
      $display("test table done");
      {advanced_config_reg, host_wdata, rate_select_wr} = {8'h11, 3'h5};
      step(1);
      `CHK("rate", 2'h2, extra_rate_outputs)
      `CHK("xrate0", 1'h0, xrate0_pin)
      `CHK("xrate1", 1'h1, density_pin)
      {rate_select_wr, config_control_wr, host_wdata} = 4'h5;
      step(1);
      `CHK("rate b2b", 2'h1, primary_rate_outputs)
      {config_control_wr, advanced_config_reg, host_wdata, xrate0_pin_default} = {9'h0, 3'h7};
      density_select_out = 1'h1;
      step(2);
      `CHK("rate held", 2'h1, extra_rate_outputs)
      `CHK("pin default", 1'h1, xrate0_pin)
      `CHK("density", 1'h1, density_pin)
      $display("test rate done");
      {function_control_reg, advanced_config_reg, drive_type_pin_in} = {16'h0004, 1'h1};
      step(1);
      `CHK("tape oe", 1'h0, tape_pin_oe)
      `CHK("drive type", 1'h1, drive_type_in_second)
      advanced_config_reg = 8'h06;
      tape_pin_default = 1'h1;
      step(1);
      `CHK("drive off", 1'h0, drive_type_in_second)
      `CHK("tape default", 1'h1, tape_pin_out)
      `CHK("tape default oe", 1'h1, tape_pin_oe)
      {test_mode, divisor_latch_access, baud_tap, serial_tx_out} = 7'h59;
      step(1);
      `CHK("baud on", 2'h0, baud_tap_output)
      test_mode = 1'h0;
      step(1);
      `CHK("baud off", 2'h1, baud_tap_output)
      $display("test pins done");
      give_verdict();
   end
endmodule
`default_nettype wire
